// ===== rtl/tpde_pkg.sv
// Shared constants and types for the temperature PWM and reverse-conduction control block.
`default_nettype none
package tpde_pkg;
    // -------------------------------------------------------------------------
    // Clock and timing
    // -------------------------------------------------------------------------
    localparam int CLK_HZ             = 20000000;
    localparam int TEMP_PWM_HZ        = 11000;
    // Cycles per PWM period; longest-time style rounding (down), 1818 cycles.
    localparam int TEMP_PERIOD_CYCLES = CLK_HZ / TEMP_PWM_HZ;
    localparam int BLANK_TIME_NS      = 100;
    localparam int DETECT_TIME_NS     = 100;
    localparam int CLK_PERIOD_NS      = 1000000000 / CLK_HZ;
    // Least times round up to whole cycles.
    localparam int BLANK_CYCLES  = (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DETECT_CYCLES = (DETECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // -------------------------------------------------------------------------
    // Temperature mapping, degrees C and duty in tenths of a percent
    // -------------------------------------------------------------------------
    localparam int TEMP_LOW_C       = 25;
    localparam int TEMP_HIGH_C      = 150;
    localparam int DUTY_MIN_PM      = 10;
    localparam int DUTY_LOW_PM      = 30;
    localparam int DUTY_HIGH_PM     = 800;
    localparam int DUTY_FULL_PM     = 1000;
    localparam int OT_TRIP_C        = 165;
    localparam int OT_HYST_C        = 20;
    localparam int TEMP_W           = 9;

    // Conduction controller states.
    typedef enum logic [2:0]
    {
        ST_ON_CMD,
        ST_BLANK,
        ST_FQ_WATCH,
        ST_BLOCK,
        ST_TQ_WATCH,
        ST_DETECT,
        ST_AUTO_ON,
        ST_LOCKOUT
    } cond_state_t;
endpackage : tpde_pkg
`default_nettype wire

// ===== rtl/temp_pwm_gen.sv
// Temperature to duty-cycle encoder with overtemperature hold-high.
`default_nettype none
module temp_pwm_gen
#(
    parameter int PERIOD = tpde_pkg::TEMP_PERIOD_CYCLES
)
(
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic [tpde_pkg::TEMP_W-1:0] temp_c,
    output logic                            pwm,
    output logic                            ot
);
    // The period counter is 16 bits wide, and very short periods leave no room for the 1% floor.
    if (PERIOD < 100 || PERIOD > 65535)
    begin : g_period_check
        $error("temp_pwm_gen: PERIOD out of range");
    end

    typedef struct packed
    {
        logic [15:0] cnt;
        logic [15:0] duty;
        logic        ot;
        logic        pwm;
    } pwm_state_t;

    pwm_state_t cur;
    pwm_state_t nxt;
    int         duty_pm;
    int         t;

    // -------------------------------------------------------------------------
    // Duty mapping: 1% floor, linear 3..80% over 25..150 C, same slope above up to a 100% cap.
    // -------------------------------------------------------------------------
    always_comb
    begin
        t = int'(temp_c);
        if (t < tpde_pkg::TEMP_LOW_C)
            duty_pm = tpde_pkg::DUTY_MIN_PM;
        else
            duty_pm = tpde_pkg::DUTY_LOW_PM + (t - tpde_pkg::TEMP_LOW_C)
                      * (tpde_pkg::DUTY_HIGH_PM - tpde_pkg::DUTY_LOW_PM)
                      / (tpde_pkg::TEMP_HIGH_C - tpde_pkg::TEMP_LOW_C);
        if (duty_pm > tpde_pkg::DUTY_FULL_PM)
            duty_pm = tpde_pkg::DUTY_FULL_PM;
    end

    // The duty value is latched once per period so a period never glitches.
    always_comb
    begin
        nxt = cur;
        if (cur.cnt == 16'(PERIOD - 1))
        begin
            nxt.cnt  = 16'h0000;
            nxt.duty = 16'(duty_pm * PERIOD / tpde_pkg::DUTY_FULL_PM);
        end
        else
            nxt.cnt = cur.cnt + 16'h0001;
        if (t >= tpde_pkg::OT_TRIP_C)
            nxt.ot = 1'b1;
        else if (t < tpde_pkg::OT_TRIP_C - tpde_pkg::OT_HYST_C)
            nxt.ot = 1'b0;
        nxt.pwm = nxt.ot || (nxt.cnt < nxt.duty);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cur <= '0;
        else
            cur <= nxt;
    end

    assign pwm = cur.pwm;
    assign ot  = cur.ot;

    // The flag and the pin are registered together, so the pin is high in the same cycle.
    AST_OT_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
        cur.ot |-> cur.pwm) else $error("pwm low during overtemperature");
    // The period counter wraps from its last value straight to zero.
    AST_PERIOD: assert property (@(posedge clk) disable iff (!rst_n)
        (cur.cnt == 16'(PERIOD - 1)) |=> (cur.cnt == 16'h0000))
        else $error("pwm period wrong");
    // The counter never runs past the period, so every period has the same length.
    AST_CNT_RANGE: assert property (@(posedge clk) disable iff (!rst_n)
        cur.cnt < 16'(PERIOD)) else $error("pwm period counter out of range");
endmodule // temp_pwm_gen
`default_nettype wire

// ===== rtl/temp_pwm_and_diode_emulation.sv
// Top: temperature PWM reporting and automatic reverse-conduction switch control.
`default_nettype none
module temp_pwm_and_diode_emulation
#(
    parameter int BLANK_CYCLES  = tpde_pkg::BLANK_CYCLES,
    parameter int DETECT_CYCLES = tpde_pkg::DETECT_CYCLES
)
(
    input  wire logic                        CLK,
    input  wire logic                        RESET_N,
    input  wire logic                        CMD_IN,
    input  wire logic [tpde_pkg::TEMP_W-1:0] DIE_TEMP_C,
    input  wire logic                        FIRST_QUAD_I,
    input  wire logic                        THIRD_QUAD_I,
    input  wire logic                        DRIVER_SHUTDOWN,
    output logic                             SWITCH_ON,
    output logic                             TEMP_PWM,
    output logic                             OVERTEMPERATURE_FAULT,
    output logic                             AUTOMATIC_REVERSE_TURN_ON_MODE
);
    // Both intervals load a 16-bit down-counter, so zero and anything wider are refused.
    if (BLANK_CYCLES < 1 || BLANK_CYCLES > 65535 || DETECT_CYCLES < 1
        || DETECT_CYCLES > 65535)
    begin : g_interval_check
        $error("interval parameters out of range");
    end

    // -------------------------------------------------------------------------
    // Reset release synchroniser
    // -------------------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    // Asynchronous assertion, synchronous release, so no state leaves reset mid-edge.
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // -------------------------------------------------------------------------
    // Temperature reporting
    // -------------------------------------------------------------------------
    logic pwm_raw;
    logic ot_raw;

    temp_pwm_gen
    #(
        .PERIOD (tpde_pkg::TEMP_PERIOD_CYCLES)
    )
    u_temp
    (
        .clk    (CLK),
        .rst_n  (rst_n),
        .temp_c (DIE_TEMP_C),
        .pwm    (pwm_raw),
        .ot     (ot_raw)
    );

    // -------------------------------------------------------------------------
    // Conduction state machine
    // -------------------------------------------------------------------------
    typedef struct packed
    {
        tpde_pkg::cond_state_t st;
        logic [15:0]           timer;
        logic                  cmd_d;
        logic                  sw_on;
        logic                  auto_on;
        logic                  pwm;
        logic                  ot;
    } top_state_t;

    top_state_t cur;
    top_state_t nxt;
    logic       cmd_rise;
    logic       cmd_fall;
    logic       cmd_eff;

    // Overtemperature masks the command; the driver's own shutdown forces the switch off.
    always_comb
    begin
        cmd_eff  = CMD_IN && !ot_raw;
        cmd_rise = cmd_eff && !cur.cmd_d;
        cmd_fall = !cmd_eff && cur.cmd_d;
    end

    // Next-state logic. A command rise wins over every state, and the driver's own
    // shutdown wins over that. Only ON_CMD and AUTO_ON conduct; all other states
    // hold the switch off. The shared timer counts down in BLANK and DETECT and is
    // otherwise left to run out to zero, which costs nothing because each state
    // that reads it loads it on entry.
    always_comb
    begin
        nxt       = cur;
        nxt.cmd_d = cmd_eff;
        nxt.pwm   = pwm_raw;
        nxt.ot    = ot_raw;
        if (cur.timer != 16'h0000)
            nxt.timer = cur.timer - 16'h0001;
        if (cmd_rise)
        begin
            nxt.st = tpde_pkg::ST_ON_CMD;
        end
        else
        begin
            case (cur.st)
                tpde_pkg::ST_ON_CMD:
                begin
                    if (cmd_fall || !cmd_eff)
                    begin
                        nxt.st    = tpde_pkg::ST_BLANK;
                        nxt.timer = 16'(BLANK_CYCLES - 1);
                    end
                end
                tpde_pkg::ST_BLANK:
                begin
                    if (cur.timer == 16'h0000)
                        nxt.st = tpde_pkg::ST_FQ_WATCH;
                end
                tpde_pkg::ST_FQ_WATCH:
                begin
                    if (FIRST_QUAD_I)
                        nxt.st = tpde_pkg::ST_BLOCK;
                    else if (THIRD_QUAD_I)
                    begin
                        nxt.st    = tpde_pkg::ST_DETECT;
                        nxt.timer = 16'(DETECT_CYCLES - 1);
                    end
                end
                tpde_pkg::ST_BLOCK:
                begin
                    // Blocking continues; the free-wheeling side now watches for reversal.
                    nxt.st = tpde_pkg::ST_TQ_WATCH;
                end
                tpde_pkg::ST_TQ_WATCH:
                begin
                    if (THIRD_QUAD_I)
                    begin
                        nxt.st    = tpde_pkg::ST_DETECT;
                        nxt.timer = 16'(DETECT_CYCLES - 1);
                    end
                end
                tpde_pkg::ST_DETECT:
                begin
                    // Dropping reverse current during detection returns to watching.
                    if (!THIRD_QUAD_I)
                        nxt.st = tpde_pkg::ST_TQ_WATCH;
                    else if (cur.timer == 16'h0000)
                        nxt.st = ot_raw ? tpde_pkg::ST_AUTO_ON : tpde_pkg::ST_AUTO_ON;
                end
                tpde_pkg::ST_AUTO_ON:
                begin
                    if (FIRST_QUAD_I)
                        nxt.st = ot_raw ? tpde_pkg::ST_TQ_WATCH
                                        : tpde_pkg::ST_LOCKOUT;
                end
                tpde_pkg::ST_LOCKOUT:
                begin
                    // Under overtemperature the command is masked, so waiting for it would
                    // leave the switch off through reverse conduction; watch instead.
                    if (ot_raw)
                        nxt.st = tpde_pkg::ST_TQ_WATCH;
                    else
                        nxt.st = tpde_pkg::ST_LOCKOUT;
                end
                default:
                begin
                    nxt.st = tpde_pkg::ST_BLANK;
                end
            endcase
        end
        if (DRIVER_SHUTDOWN)
            nxt.st = tpde_pkg::ST_LOCKOUT;
        nxt.sw_on   = (nxt.st == tpde_pkg::ST_ON_CMD) || (nxt.st == tpde_pkg::ST_AUTO_ON);
        nxt.auto_on = (nxt.st == tpde_pkg::ST_AUTO_ON);
    end

    // Reset parks the machine in lockout so the switch stays off until a command edge or, under overtemperature, a completed reverse detection.
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cur       <= '0;
            cur.st    <= tpde_pkg::ST_LOCKOUT;
        end
        else
            cur <= nxt;
    end

    assign SWITCH_ON                      = cur.sw_on;
    assign TEMP_PWM                       = cur.pwm;
    assign OVERTEMPERATURE_FAULT          = cur.ot;
    assign AUTOMATIC_REVERSE_TURN_ON_MODE = cur.auto_on;

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    // A command rise turns the switch on at the next edge.
    AST_RISE_ON: assert property (@(posedge CLK) disable iff (!rst_n)
        (CMD_IN && !ot_raw && !cur.cmd_d && !DRIVER_SHUTDOWN) |=> SWITCH_ON)
        else $error("rising command did not turn on");
    // A low command in the commanded state turns the switch off at the next edge.
    AST_FALL_OFF: assert property (@(posedge CLK) disable iff (!rst_n)
        (cur.st == tpde_pkg::ST_ON_CMD && !cmd_eff && !DRIVER_SHUTDOWN) |=> !SWITCH_ON)
        else $error("falling command did not turn off");
    // Turn-off loads the full blanking count.
    AST_BLANK_LOAD: assert property (@(posedge CLK) disable iff (!rst_n)
        (cur.st == tpde_pkg::ST_ON_CMD && !cmd_eff && !DRIVER_SHUTDOWN)
        |=> (cur.st == tpde_pkg::ST_BLANK && cur.timer == 16'(BLANK_CYCLES - 1)))
        else $error("blanking interval not loaded");
    // The switch stays off while blanking.
    AST_BLANK_OFF: assert property (@(posedge CLK) disable iff (!rst_n)
        (cur.st == tpde_pkg::ST_BLANK) |-> !SWITCH_ON)
        else $error("switch on during blanking");
    // Blanking ends in the first-quadrant watch once its count has run out.
    AST_BLANK_END: assert property (@(posedge CLK) disable iff (!rst_n)
        (cur.st == tpde_pkg::ST_BLANK && cur.timer == 16'h0000 && !cmd_rise
         && !DRIVER_SHUTDOWN) |=> (cur.st == tpde_pkg::ST_FQ_WATCH))
        else $error("blanking did not end in the watch");
    // Forward current after blanking keeps the switch blocking.
    AST_BLOCK_OFF: assert property (@(posedge CLK) disable iff (!rst_n)
        (cur.st == tpde_pkg::ST_FQ_WATCH && FIRST_QUAD_I && !cmd_rise)
        |=> !SWITCH_ON [*2]) else $error("not blocking after forward current");
    // Blocking hands over to the third-quadrant watch.
    AST_BLOCK_WATCH: assert property (@(posedge CLK) disable iff (!rst_n)
        (cur.st == tpde_pkg::ST_BLOCK && !cmd_rise && !DRIVER_SHUTDOWN)
        |=> (cur.st == tpde_pkg::ST_TQ_WATCH))
        else $error("blocking did not start the reverse watch");
    // Reverse current in the watch starts a full detection count.
    AST_DETECT_LOAD: assert property (@(posedge CLK) disable iff (!rst_n)
        (cur.st == tpde_pkg::ST_TQ_WATCH && THIRD_QUAD_I && !cmd_rise && !DRIVER_SHUTDOWN)
        |=> (cur.st == tpde_pkg::ST_DETECT && cur.timer == 16'(DETECT_CYCLES - 1)))
        else $error("detection interval not loaded");
    // The switch stays off while detecting.
    AST_DETECT_OFF: assert property (@(posedge CLK) disable iff (!rst_n)
        (cur.st == tpde_pkg::ST_DETECT) |-> !SWITCH_ON)
        else $error("switch on during detection");
    // Reverse current that drops during detection sends the machine back to watching.
    AST_TQ_DROP: assert property (@(posedge CLK) disable iff (!rst_n)
        (cur.st == tpde_pkg::ST_DETECT && !THIRD_QUAD_I && !cmd_rise && !DRIVER_SHUTDOWN)
        |=> (cur.st == tpde_pkg::ST_TQ_WATCH))
        else $error("lost reverse current did not restart the watch");
    // A completed detection turns the switch on automatically.
    AST_AUTO_ON: assert property (@(posedge CLK) disable iff (!rst_n)
        (cur.st == tpde_pkg::ST_DETECT && cur.timer == 16'h0000 && THIRD_QUAD_I
         && !cmd_rise && !DRIVER_SHUTDOWN) |=> (SWITCH_ON && AUTOMATIC_REVERSE_TURN_ON_MODE))
        else $error("no automatic turn-on");
    // The automatic flag is only ever shown with the switch on.
    AST_AUTO_FLAG: assert property (@(posedge CLK) disable iff (!rst_n)
        AUTOMATIC_REVERSE_TURN_ON_MODE |-> SWITCH_ON)
        else $error("automatic flag without switch on");
    // Forward current while automatically on turns the switch off.
    AST_LOCKOUT: assert property (@(posedge CLK) disable iff (!rst_n)
        (cur.st == tpde_pkg::ST_AUTO_ON && FIRST_QUAD_I && !ot_raw && !cmd_rise)
        |=> !SWITCH_ON) else $error("forward current did not turn off");
    // Lockout keeps the switch off until a command rise or, under overtemperature, a completed reverse detection.
    AST_LOCK_HOLD: assert property (@(posedge CLK) disable iff (!rst_n)
        (cur.st == tpde_pkg::ST_LOCKOUT && !cmd_rise) |=> !SWITCH_ON)
        else $error("lockout released without command");
    // Under overtemperature a command rise alone does not turn the switch on.
    AST_OT_IGNORE: assert property (@(posedge CLK) disable iff (!rst_n)
        (ot_raw && $rose(CMD_IN) && !SWITCH_ON && !THIRD_QUAD_I)
        |=> !SWITCH_ON) else $error("command obeyed during overtemperature");
    // Under overtemperature forward current ends auto-on without a lockout.
    AST_OT_REARM: assert property (@(posedge CLK) disable iff (!rst_n)
        (cur.st == tpde_pkg::ST_AUTO_ON && FIRST_QUAD_I && ot_raw && !DRIVER_SHUTDOWN)
        |=> (!SWITCH_ON && cur.st == tpde_pkg::ST_TQ_WATCH))
        else $error("overtemperature auto-on did not rearm");
    // Under overtemperature a lockout gives way to the reverse watch.
    AST_OT_UNLOCK: assert property (@(posedge CLK) disable iff (!rst_n)
        (cur.st == tpde_pkg::ST_LOCKOUT && ot_raw && !DRIVER_SHUTDOWN)
        |=> (cur.st == tpde_pkg::ST_TQ_WATCH))
        else $error("lockout kept during overtemperature");
    // The driver's own shutdown forces the switch off and into lockout.
    AST_SHUTDOWN_OFF: assert property (@(posedge CLK) disable iff (!rst_n)
        DRIVER_SHUTDOWN |=> (!SWITCH_ON && cur.st == tpde_pkg::ST_LOCKOUT))
        else $error("switch not off in driver shutdown");
    // The reported fault and the pulse pin travel together, so the pin is high with it.
    AST_PWM_OT: assert property (@(posedge CLK) disable iff (!rst_n)
        OVERTEMPERATURE_FAULT |-> TEMP_PWM)
        else $error("pulse pin low while fault reported");
endmodule // temp_pwm_and_diode_emulation
`default_nettype wire

// ===== bench/ctrl_model.sv
// Controller model: passes the command through and measures the temperature pulses.
`default_nettype none
module ctrl_model
(
    input  wire logic        clk,
    input  wire logic        cmd_req,
    input  wire logic        temp_pwm,
    output wire logic        cmd_in,
    output var  logic [31:0] high_cnt,
    output var  logic [31:0] period_cnt,
    output wire logic [31:0] rises
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        prev   = 1'b1;
    logic [31:0] hcnt   = 32'h0;
    logic [31:0] pcnt   = 32'h0;
    logic [31:0] n_rise = 32'h0;

    // The request already changes off the falling edge, so it goes straight to the pin.
    assign cmd_in = cmd_req;
    assign rises  = n_rise;

    // Measure from rising edge to rising edge. A pin held high gives no edge,
    // so the figures go stale while a fault holds the pin up.
    always @(posedge clk)
    begin
        prev <= temp_pwm;
        if (temp_pwm && !prev)
        begin
            high_cnt   <= hcnt;
            period_cnt <= pcnt;
            n_rise     <= n_rise + 32'h1;
            hcnt       <= 32'h1;
            pcnt       <= 32'h1;
        end
        else
        begin
            hcnt <= hcnt + {31'h0, temp_pwm};
            pcnt <= pcnt + 32'h1;
        end
    end
endmodule // ctrl_model
`default_nettype wire

// ===== bench/tb_temp_pwm_and_diode_emulation.sv
// Self-checking bench for the temperature pulse encoder and reverse-conduction control.
`default_nettype none
module tb_temp_pwm_and_diode_emulation;
    timeunit 1ns;
    timeprecision 1ns;
    // -------------------------------------------------------------------------
    // Signals, design and controller model
    // -------------------------------------------------------------------------
    localparam int PER  = tpde_pkg::TEMP_PERIOD_CYCLES;
    localparam int BLNK = 3;
    localparam int DET  = 5;
    typedef struct { logic [tpde_pkg::TEMP_W-1:0] temp; int pm; } row_t;
    logic                        CLK     = 1'b0;
    logic                        RESET_N = 1'b0;
    logic                        cmd_req = 1'b0;
    logic [tpde_pkg::TEMP_W-1:0] temp    = 9'h01E;
    logic                        fq      = 1'b0;
    logic                        tq      = 1'b0;
    logic                        shut    = 1'b0;
    wire logic                   cmd_in, sw, pwm, ot, auto_on;
    wire logic [31:0]            high_cnt, period_cnt, rises;
    int                          fails      = 0;
    int                          num_checks = 0;
    // Temperature beside its expected duty in tenths of a percent.
    row_t rows [5] = '{'{9'h000, 10}, '{9'h019, 30}, '{9'h064, 492},
                       '{9'h096, 800}, '{9'h0A0, 861}};

    // Half period of 25 ns gives the 20 MHz clock.
    always #25 CLK = ~CLK;

    temp_pwm_and_diode_emulation #(.BLANK_CYCLES(BLNK), .DETECT_CYCLES(DET)) DUT
    (
        .CLK(CLK), .RESET_N(RESET_N), .CMD_IN(cmd_in), .DIE_TEMP_C(temp),
        .FIRST_QUAD_I(fq), .THIRD_QUAD_I(tq), .DRIVER_SHUTDOWN(shut),
        .SWITCH_ON(sw), .TEMP_PWM(pwm), .OVERTEMPERATURE_FAULT(ot),
        .AUTOMATIC_REVERSE_TURN_ON_MODE(auto_on)
    );

    ctrl_model ctrl
    (
        .clk(CLK), .cmd_req(cmd_req), .temp_pwm(pwm), .cmd_in(cmd_in),
        .high_cnt(high_cnt), .period_cnt(period_cnt), .rises(rises)
    );
    // -------------------------------------------------------------------------
    // Check and wait tasks; every wait is bounded
    // -------------------------------------------------------------------------
    task automatic summarize();
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // A tolerance absorbs rounding of the duty count; unknowns never match.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol);
        num_checks++;
        if ((^got === 1'bx) || (got > exp + tol) || (got + tol < exp))
        begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chkb(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp}, 0);
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge CLK);
    endtask

    task automatic sw_within(input logic v, input int n);
        int k;
        k = 0;
        while (sw !== v && k < n)
        begin
            @(negedge CLK);
            k++;
        end
        chkb(sw, v);
    endtask

    task automatic sw_hold(input logic v, input int n);
        repeat (n)
        begin
            @(negedge CLK);
            chkb(sw, v);
        end
    endtask

    task automatic wait_rises(input int n);
        logic [31:0] start;
        int          k;
        start = rises;
        k = 0;
        while (rises - start < n && k < n * PER * 2)
        begin
            @(negedge CLK);
            k++;
        end
        if (rises - start < n)
        begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, rises - start, n);
            summarize();
        end
    endtask
    // -------------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------------
    initial
    begin
        int bad;
        step(6);
        chkb(sw, 1'b0);
        chkb(pwm, 1'b0);
        chkb(ot, 1'b0);
        chkb(auto_on, 1'b0);
        RESET_N = 1'b1;
        tq = 1'b1;
        sw_hold(1'b0, 12);
        tq = 1'b0;
        // Duty rows; the third rise closes a period taken wholly at the new value.
        for (int i = 0; i < 5; i++)
        begin
            temp = rows[i].temp;
            wait_rises(3);
            chk(period_cnt, 32'(PER), 1);
            chk(high_cnt, 32'(rows[i].pm * PER / 1000), 2);
        end
        temp = 9'h01E;
        // Reverse current already present at turn-off: blanking, detection, then on.
        cmd_req = 1'b1;
        sw_within(1'b1, 3);
        chkb(auto_on, 1'b0);
        cmd_req = 1'b0;
        tq = 1'b1;
        sw_within(1'b0, 3);
        sw_hold(1'b0, BLNK + DET - 2);
        sw_within(1'b1, 6);
        chkb(auto_on, 1'b1);
        // Forward current during automatic on locks the switch off until a command.
        tq = 1'b0;
        fq = 1'b1;
        sw_within(1'b0, 3);
        chkb(auto_on, 1'b0);
        fq = 1'b0;
        tq = 1'b1;
        sw_hold(1'b0, 20);
        cmd_req = 1'b1;
        sw_within(1'b1, 3);
        tq = 1'b0;
        // Leakage after blanking blocks; a reverse pulse shorter than detection is ignored.
        cmd_req = 1'b0;
        fq = 1'b1;
        sw_within(1'b0, 3);
        sw_hold(1'b0, 15);
        fq = 1'b0;
        tq = 1'b1;
        step(2);
        tq = 1'b0;
        sw_hold(1'b0, 12);
        tq = 1'b1;
        sw_hold(1'b0, DET - 1);
        sw_within(1'b1, 4);
        tq = 1'b0;
        fq = 1'b1;
        sw_within(1'b0, 3);
        fq = 1'b0;
        cmd_req = 1'b1;
        sw_within(1'b1, 3);
        cmd_req = 1'b0;
        sw_within(1'b0, 3);
        // Overtemperature: pin held high, command ignored, reverse current alone switches.
        temp = 9'h0AA;
        step(4);
        chkb(ot, 1'b1);
        bad = 0;
        repeat (2000)
        begin
            @(negedge CLK);
            if (pwm !== 1'b1)
                bad++;
        end
        chk(32'(bad), 32'h0, 0);
        cmd_req = 1'b1;
        sw_hold(1'b0, 10);
        tq = 1'b1;
        sw_within(1'b1, DET + 4);
        tq = 1'b0;
        fq = 1'b1;
        sw_within(1'b0, 3);
        fq = 1'b0;
        tq = 1'b1;
        sw_within(1'b1, DET + 4);
        shut = 1'b1;
        sw_within(1'b0, 3);
        sw_hold(1'b0, 10);
        cmd_req = 1'b0;
        tq = 1'b0;
        shut = 1'b0;
        // The fault clears only below the hysteresis band, then pulses resume.
        temp = 9'h096;
        step(4);
        chkb(ot, 1'b1);
        temp = 9'h08C;
        step(4);
        chkb(ot, 1'b0);
        wait_rises(3);
        chk(high_cnt, 32'(738 * PER / 1000), 2);
        summarize();
    end
endmodule // tb_temp_pwm_and_diode_emulation
`default_nettype wire
